/* File: logic/char_serializer.sv */
// serialiser for one 8- or 9-data-bit character, one stop bit
// assumes start is only raised while busy is low
`timescale 1ns/100ps
module char_serializer
   import esc_tx_pkg::*;
#(
   parameter int unsigned BAUD_DIV = BAUD_DIV_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire char_t ch,
   input wire logic brk,
   output logic txd,
   output logic busy
);
   logic [10:0] shift_q;
   logic [3:0] left_q;
   logic [15:0] baud_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shift_q <= '1;
         left_q <= 4'h0;
         baud_q <= 16'h0000;
      end else if (start) begin
         // in 8-bit framing the slot after bit 7 is the stop bit, never the ninth bit
         shift_q <= {1'b1, ch.nine ? ch.data[8] : 1'b1, ch.data[7:0], 1'b0};
         left_q <= ch.nine ? 4'hb : 4'ha;
         baud_q <= 16'(BAUD_DIV - 1);
      end else if (left_q != 4'h0) begin
         if (baud_q == 16'h0000) begin
            baud_q <= 16'(BAUD_DIV - 1);
            shift_q <= {1'b1, shift_q[10:1]};
            left_q <= left_q - 4'h1;
         end else begin
            baud_q <= baud_q - 16'h0001;
         end
      end
   end

   // break forces spacing level regardless of any character in flight
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txd <= 1'b1;
         busy <= 1'b0;
      end else begin
         txd <= brk ? 1'b0 : (start ? 1'b0 : shift_q[0]);
         busy <= start || (left_q > 4'h1) || (left_q == 4'h1 && baud_q != 16'h0000);
      end
   end
endmodule

/* File: logic/esc_tx_pkg.sv */
// shared constants and carrier types for the escape-sequence transmitter
// assumes a single 200 MHz system clock
package esc_tx_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned BREAK_UNIT_US = 100;
   localparam int unsigned DELAY_UNIT_MS = 1;
   localparam int unsigned BREAK_UNIT_CYC = CLK_HZ / 1_000_000 * BREAK_UNIT_US;
   localparam int unsigned DELAY_UNIT_CYC = CLK_HZ / 1_000 * DELAY_UNIT_MS;
   localparam int unsigned BAUD_DIV_DEF = 1736;
   localparam logic [7:0] ESC_BYTE = 8'h1b;
   localparam logic [7:0] CMD_BREAK = 8'h11;
   localparam logic [7:0] CMD_NINTH = 8'h12;
   localparam logic [7:0] CMD_DELAY = 8'h13;
   localparam logic [7:0] CMD_RTS = 8'h14;
   localparam logic RTS_RESET = 1'b0;
   localparam logic NINTH_RESET = 1'b0;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } tx_byte_t;

   typedef struct packed {
      logic [8:0] data;
      logic nine;
   } char_t;
endpackage

/* File: logic/serial_tx_escape_sequencer.sv */
// byte-stream transmitter that acts on in-band escape sequences
// assumes byte source and control pins are synchronous to clk
`timescale 1ns/100ps
module serial_tx_escape_sequencer
   import esc_tx_pkg::*;
#(
   parameter int unsigned BREAK_CYC = BREAK_UNIT_CYC,
   parameter int unsigned DELAY_CYC = DELAY_UNIT_CYC,
   parameter int unsigned BAUD_DIV = BAUD_DIV_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire tx_byte_t in_byte,
   output logic in_ready,
   input wire logic escape_processing_on,
   input wire logic escape_processing_off,
   input wire logic nine_bit_mode_on,
   output logic txd,
   output logic rts,
   output logic ninth_bit,
   output logic break_active
);
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_CMD = 6'b000010,
      S_ARG = 6'b000100,
      S_SEND = 6'b001000,
      S_BREAK = 6'b010000,
      S_WAIT = 6'b100000
   } state_t;

   state_t state_q;
   logic esc_en_q;
   logic [7:0] cmd_q;
   logic [7:0] data_q;
   logic [7:0] units_q;
   logic [31:0] tick_q;
   logic wait_pend_q;
   logic [7:0] wait_units_q;
   logic ser_start;
   logic ser_busy;
   logic take;
   logic resend_q;
   char_t ch;

   function automatic logic known_cmd(input logic [7:0] b);
      known_cmd = (b == CMD_BREAK) || (b == CMD_NINTH) || (b == CMD_DELAY) || (b == CMD_RTS);
   endfunction

   assign take = in_byte.valid && in_ready;
   assign ser_start = (state_q == S_SEND) && !ser_busy && !wait_pend_q;
   assign ch = '{data: {ninth_bit, data_q}, nine: nine_bit_mode_on};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         esc_en_q <= 1'b0;
      end else if (escape_processing_off) begin
         esc_en_q <= 1'b0;
      end else if (escape_processing_on) begin
         esc_en_q <= 1'b1;
      end
   end

   // main sequencer; an escape not followed by a known command is sent as data
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_IDLE;
         cmd_q <= 8'h00;
         data_q <= 8'h00;
         resend_q <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (take) begin
                  data_q <= in_byte.data;
                  if (esc_en_q && in_byte.data == ESC_BYTE) begin
                     state_q <= S_CMD;
                  end else begin
                     state_q <= S_SEND;
                  end
               end
            end
            S_CMD: begin
               if (take) begin
                  cmd_q <= in_byte.data;
                  if (known_cmd(in_byte.data)) begin
                     state_q <= S_ARG;
                  end else begin
                     // unknown pair: escape byte goes out, second byte is reparsed
                     state_q <= S_SEND;
                     // a flag, not cmd_q, marks the pending byte so a zero byte is kept
                     resend_q <= 1'b1;
                  end
               end
            end
            S_ARG: begin
               if (take) begin
                  if (cmd_q == CMD_BREAK && in_byte.data != 8'h00) begin
                     state_q <= S_BREAK;
                  end else begin
                     state_q <= S_IDLE;
                  end
               end
            end
            S_SEND: begin
               if (ser_start) begin
                  state_q <= resend_q ? S_WAIT : S_IDLE;
               end
            end
            S_WAIT: begin
               // resend the byte that followed a lone escape
               if (!ser_busy) begin
                  data_q <= cmd_q;
                  cmd_q <= 8'h00;
                  resend_q <= 1'b0;
                  state_q <= (esc_en_q && cmd_q == ESC_BYTE) ? S_CMD : S_SEND;
               end
            end
            S_BREAK: begin
               if (units_q == 8'h00) begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   assign in_ready = (state_q == S_IDLE || state_q == S_CMD || state_q == S_ARG)
      && !(state_q == S_IDLE && (ser_busy || wait_pend_q)) ? 1'b1 : 1'b0;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ninth_bit <= NINTH_RESET;
         rts <= RTS_RESET;
      end else if (state_q == S_ARG && take) begin
         if (cmd_q == CMD_NINTH && in_byte.data == 8'h00) ninth_bit <= 1'b0;
         if (cmd_q == CMD_NINTH && in_byte.data == 8'h01) ninth_bit <= 1'b1;
         if (cmd_q == CMD_RTS && in_byte.data == 8'h00) rts <= 1'b1;
         if (cmd_q == CMD_RTS && in_byte.data == 8'h01) rts <= 1'b0;
      end
   end

   // shared unit timer for break and inter-character delay
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         units_q <= 8'h00;
         tick_q <= 32'h0;
         wait_pend_q <= 1'b0;
         wait_units_q <= 8'h00;
         break_active <= 1'b0;
      end else begin
         if (state_q == S_ARG && take && in_byte.data != 8'h00) begin
            if (cmd_q == CMD_BREAK) begin
               units_q <= in_byte.data;
               tick_q <= 32'(BREAK_CYC - 1);
               break_active <= 1'b1;
            end else if (cmd_q == CMD_DELAY) begin
               wait_units_q <= in_byte.data;
               tick_q <= 32'(DELAY_CYC - 1);
               wait_pend_q <= 1'b1;
            end
         end else if (break_active || wait_pend_q) begin
            if (tick_q == 32'h0) begin
               tick_q <= 32'(break_active ? BREAK_CYC - 1 : DELAY_CYC - 1);
               if (break_active) begin
                  units_q <= units_q - 8'h01;
                  if (units_q == 8'h01) break_active <= 1'b0;
               end else begin
                  wait_units_q <= wait_units_q - 8'h01;
                  if (wait_units_q == 8'h01) wait_pend_q <= 1'b0;
               end
            end else begin
               tick_q <= tick_q - 32'h1;
            end
         end
      end
   end

   char_serializer #(
      .BAUD_DIV(BAUD_DIV)
   ) u_ser (
      .clk(clk),
      .nrst(nrst),
      .start(ser_start),
      .ch(ch),
      .brk(break_active),
      .txd(txd),
      .busy(ser_busy)
   );

   a_break_len: assert property (@(posedge clk) disable iff (!nrst)
      $rose(break_active) |-> break_active [*8])
      else $error("break shorter than expected");
   a_break_line: assert property (@(posedge clk) disable iff (!nrst)
      break_active |=> !txd)
      else $error("line not in break");
   a_no_esc_tx: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == S_CMD && take && known_cmd(in_byte.data)) |=> !ser_busy && !ser_start)
      else $error("escape byte transmitted");
   a_plain_pass: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == S_IDLE && take && !esc_en_q) |=> state_q == S_SEND)
      else $error("byte not passed through");
   a_ninth_clr: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == S_ARG && take && cmd_q == CMD_NINTH && in_byte.data == 8'h00) |=> !ninth_bit)
      else $error("ninth bit not cleared");
   a_ninth_set: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == S_ARG && take && cmd_q == CMD_NINTH && in_byte.data == 8'h01) |=> ninth_bit)
      else $error("ninth bit not set");
   a_delay_hold: assert property (@(posedge clk) disable iff (!nrst)
      wait_pend_q |-> !ser_start)
      else $error("character started during delay");
   a_rts_high: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == S_ARG && take && cmd_q == CMD_RTS && in_byte.data == 8'h00) |=> rts)
      else $error("rts not raised");
   a_rts_low: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == S_ARG && take && cmd_q == CMD_RTS && in_byte.data == 8'h01) |=> !rts)
      else $error("rts not lowered");
   a_zero_count: assert property (@(posedge clk) disable iff (!nrst)
      (state_q == S_ARG && take && in_byte.data == 8'h00) |=> !$rose(break_active))
      else $error("zero count acted on");
endmodule

/* File: test/rs232_rx_model.sv */
// far-end line receiver standing for the equipment on the serial port
// assumes txd idles high and one bit lasts BAUD_DIV clocks
`timescale 1ns/100ps
module rs232_rx_model #(
   parameter int unsigned BAUD_DIV = 4
) (
   input wire logic clk,
   input wire logic txd,
   input wire logic nine,
   output logic [8:0] rx_data,
   output int rx_count
);
   logic [8:0] sh;
   int nb;
   // sampling on the falling edge keeps clear of the transmitter's flop updates
   initial begin
      rx_data = 9'h000;
      rx_count = 0;
      forever begin
         @(negedge clk);
         if (txd === 1'b0) begin
            nb = nine ? 9 : 8;
            sh = 9'h000;
            repeat (BAUD_DIV / 2) @(negedge clk);
            for (int i = 0; i < nb; i++) begin
               repeat (BAUD_DIV) @(negedge clk);
               sh[i] = txd;
            end
            repeat (BAUD_DIV) @(negedge clk);
            if (txd === 1'b1) begin
               rx_data = sh;
               rx_count++;
            end
            // a break or bad stop bit is dropped, like a real receiver would
            while (txd !== 1'b1) @(negedge clk);
         end
      end
   end
endmodule

/* File: test/tb.sv */
// self-checking bench for the escape-sequence transmitter
// assumes short sim counts: break unit 50, delay unit 20, bit time 4 clocks
// break unit is kept above one character time so a short break is not read as a character
`timescale 1ns/100ps
module tb;
   import esc_tx_pkg::*;
   localparam int BRK = 50;
   localparam int DLY = 20;
   logic clk, nrst, in_ready, escape_processing_on, escape_processing_off;
   logic nine_bit_mode_on, txd, rts, ninth_bit, break_active;
   tx_byte_t in_byte;
   logic [8:0] rx_data;
   int rx_count, seen, err_total, tests_run;
   serial_tx_escape_sequencer #(.BREAK_CYC(BRK), .DELAY_CYC(DLY), .BAUD_DIV(4)) DUT (
      .clk(clk), .nrst(nrst), .in_byte(in_byte), .in_ready(in_ready),
      .escape_processing_on(escape_processing_on), .escape_processing_off(escape_processing_off),
      .nine_bit_mode_on(nine_bit_mode_on), .txd(txd), .rts(rts), .ninth_bit(ninth_bit),
      .break_active(break_active));
   rs232_rx_model #(.BAUD_DIV(4)) far (.clk(clk), .txd(txd), .nine(nine_bit_mode_on),
      .rx_data(rx_data), .rx_count(rx_count));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic put(input logic [7:0] b);
      int n;
      n = 0;
      @(posedge clk);
      in_byte <= '{valid: 1'b1, data: b};
      do begin
         @(negedge clk);
         n++;
      end while (in_ready !== 1'b1 && n < 8000);
      if (n >= 8000) chk({15'h0, in_ready}, 16'h0001);
      @(posedge clk);
      in_byte.valid <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic get(input logic [8:0] exp);
      int n;
      n = 0;
      while (rx_count == seen && n < 6000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 6000) chk(16'(rx_count), 16'(seen + 1));
      seen++;
      chk({7'h00, rx_data}, {7'h00, exp});
   endtask
   task automatic esc(input logic [7:0] c, input logic [7:0] a);
      put(ESC_BYTE);
      put(c);
      put(a);
   endtask
   task automatic pass(input logic [7:0] b);
      put(b);
      get({1'b0, b});
   endtask
   task automatic passthru;
      pass(ESC_BYTE);
      pass(CMD_RTS);
      pass(8'h00);
      chk({15'h0, rts}, 16'h0000);
      $display("test passthru done");
   endtask
   task automatic ctl(input logic on);
      @(posedge clk);
      if (on) escape_processing_on <= 1'b1;
      else escape_processing_off <= 1'b1;
      @(posedge clk);
      escape_processing_on <= 1'b0;
      escape_processing_off <= 1'b0;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #200000;
      err_total++;
      end_sim();
   end
   initial begin
      int n;
      logic low;
      logic [7:0] cnt;
      time t0;
      nrst = 1'b0;
      in_byte = '0;
      escape_processing_on = 1'b0;
      escape_processing_off = 1'b0;
      nine_bit_mode_on = 1'b0;
      err_total = 0;
      tests_run = 0;
      seen = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      passthru();
      ctl(1'b1);
      esc(CMD_RTS, 8'h00);
      chk({15'h0, rts}, 16'h0001);
      esc(CMD_RTS, 8'h01);
      chk({15'h0, rts}, 16'h0000);
      pass(8'h41);
      put(ESC_BYTE);
      put(8'h00);
      get(9'h01b);
      get(9'h000);
      @(posedge clk);
      nine_bit_mode_on <= 1'b1;
      esc(CMD_NINTH, 8'h01);
      chk({15'h0, ninth_bit}, 16'h0001);
      put(8'h55);
      get(9'h155);
      esc(CMD_NINTH, 8'h00);
      chk({15'h0, ninth_bit}, 16'h0000);
      put(8'haa);
      get(9'h0aa);
      @(posedge clk);
      nine_bit_mode_on <= 1'b0;
      pass(8'hf0);
      $display("test escapes done");
      for (int k = 0; k < 3; k++) begin
         cnt = (k == 0) ? 8'h00 : ((k == 1) ? 8'h01 : 8'hff);
         esc(CMD_BREAK, cnt);
         n = 0;
         low = 1'b1;
         // the line is measured; break_active drops one clock before the line goes high
         while (txd === 1'b0 && n < 13000) begin
            if (break_active !== (n + 1 < int'(cnt) * BRK)) low = 1'b0;
            @(posedge clk);
            #1;
            n++;
         end
         chk(16'(n), 16'(cnt * BRK));
         chk({15'h0, low}, 16'h0001);
         pass(8'h42);
      end
      $display("test break done");
      for (int k = 0; k < 2; k++) begin
         cnt = 8'(2 * k);
         esc(CMD_DELAY, cnt);
         t0 = $time;
         put(8'h43);
         n = 0;
         while (txd !== 1'b0 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
         end
         n = int'(($time - t0) / 5);
         chk({15'h0, n >= cnt * DLY && n <= cnt * DLY + 8}, 16'h0001);
         get(9'h043);
      end
      $display("test delay done");
      ctl(1'b0);
      passthru();
      end_sim();
   end
endmodule
